// File: inc/cpu_regs_pkg.sv
// Constants and helpers shared by the core register file and its memory
package cpu_regs_pkg;

    // Word and accumulator widths
    localparam int          WORD_W    = 32;
    localparam int          ACC_W     = 56;
    localparam int          ADDR_W    = 4;

    // General register numbers
    localparam logic [3:0]  LINK_IDX  = 4'he;
    localparam logic [3:0]  SP_IDX    = 4'hf;
    localparam logic [3:0]  MEM_TOP   = 4'he;   // Highest index held in RAM
    localparam int          MEM_WORDS = 15;

    // Control register numbers
    localparam logic [2:0]  CR_STATUS   = 3'h0;
    localparam logic [2:0]  CR_MIRROR   = 3'h1;
    localparam logic [2:0]  CR_ISP      = 3'h2;
    localparam logic [2:0]  CR_USP      = 3'h3;
    localparam logic [2:0]  CR_SAVED_PC = 3'h6;

    // Status word field positions
    localparam int          SAVED_STACK_BIT = 16;
    localparam int          SAVED_IRQ_BIT   = 17;
    localparam int          SAVED_COND_BIT  = 23;
    localparam int          STACK_SEL_BIT   = 24;
    localparam int          IRQ_EN_BIT      = 25;
    localparam int          COND_BIT        = 31;

    // Status word implemented bits and reset values
    localparam logic [31:0] STATUS_WMASK = 32'h8383_0000;
    localparam logic [31:0] STATUS_RESET = 32'h0000_0000;
    localparam logic [31:0] WORD_ZERO = 32'h0000_0000;
    localparam logic [55:0] ACC_RESET = 56'h00_0000_0000_0000;

    // Return address alignment
    localparam logic [31:0] PC_ALIGN  = 32'hffff_fffc;

    // True when a register number names the stack pointer alias
    function automatic logic is_sp(input logic [3:0] idx);
        return idx == SP_IDX;
    endfunction

    // True when a register number is held in the register RAM
    function automatic logic in_mem(input logic [3:0] idx);
        return idx <= MEM_TOP;
    endfunction

endpackage

// File: hw/gpr_mem.sv
// Register RAM for general registers zero to fourteen, two registered reads
`timescale 1ns/1ps
module gpr_mem (
    // Clock and reset
    input  wire logic        ref_clk_i,
    input  wire logic        rstn_i,
    // Write port
    input  wire logic        we_i,
    input  wire logic [3:0]  waddr_i,
    input  wire logic [31:0] wdata_i,
    // Read ports
    input  wire logic [3:0]  raddr_a_i,
    input  wire logic [3:0]  raddr_b_i,
    output logic      [31:0] rdata_a_o,
    output logic      [31:0] rdata_b_o
);

    typedef struct packed {
        logic [14:0][31:0] mem;
        logic [31:0]       qa;
        logic [31:0]       qb;
    } mem_state_s;

    mem_state_s st_reg;
    mem_state_s st_next;

    // Write and read; reads return the value held before a same-cycle write
    always_comb begin
        st_next = st_reg;
        if (we_i && cpu_regs_pkg::in_mem(waddr_i)) begin
            st_next.mem[waddr_i] = wdata_i;
        end
        st_next.qa = cpu_regs_pkg::in_mem(raddr_a_i) ?
                     st_reg.mem[raddr_a_i] : cpu_regs_pkg::WORD_ZERO;
        st_next.qb = cpu_regs_pkg::in_mem(raddr_b_i) ?
                     st_reg.mem[raddr_b_i] : cpu_regs_pkg::WORD_ZERO;
    end

    // State register
    always_ff @(posedge ref_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            st_reg <= '0;
        end else begin
            st_reg <= st_next;
        end
    end

    assign rdata_a_o = st_reg.qa;
    assign rdata_b_o = st_reg.qb;

endmodule

// File: hw/cpu_register_file.sv
// Core register file: general registers, control registers, accumulator, PC
// How it works
// - Sixteen 32-bit general registers, numbered zero to fifteen.
// - A subroutine call writes its return address into register fourteen.
// - Register fifteen is interrupt stack pointer at select 0, else user.
// - A separate 56-bit multiply-accumulate accumulator is held.
// - Program counter and control registers are all 32 bits wide.
// - Five control registers, reached by control moves; both stack pointers also through register fifteen.
// - Exception copies select, enable, condition into bits 16, 17, 23.
// - Backup bits have no promised reset value; readable and writable.
// - Status bit 24 selects the stack pointer; zero after reset.
// - Status bit 25 gates interrupt acceptance; zero after reset.
// - Status bit 31 is the condition flag, set by execution, reset to 0.
// - Condition mirror always shows the current condition flag.
// - Condition mirror is read-only; writes to it change nothing.
// - Exception saves PC to backup; return restores it, low bits 00.
`timescale 1ns/1ps
module cpu_register_file (
    // Clock and reset
    input  wire logic        ref_clk_i,
    input  wire logic        rstn_i,
    // General register reads, data one cycle later
    input  wire logic [3:0]  gpr_raddr_a_i,
    input  wire logic [3:0]  gpr_raddr_b_i,
    output logic      [31:0] gpr_rdata_a_o,
    output logic      [31:0] gpr_rdata_b_o,
    // General register write
    input  wire logic        gpr_we_i,
    input  wire logic [3:0]  gpr_waddr_i,
    input  wire logic [31:0] gpr_wdata_i,
    // Subroutine call link write
    input  wire logic        call_i,
    input  wire logic [31:0] ret_addr_i,
    // Control register moves
    input  wire logic        move_to_control_i,
    input  wire logic [2:0]  ctl_waddr_i,
    input  wire logic [31:0] ctl_wdata_i,
    input  wire logic [2:0]  ctl_raddr_i,
    output logic      [31:0] ctl_rdata_o,
    // Condition flag update from execution
    input  wire logic        cond_we_i,
    input  wire logic        cond_i,
    // Program counter
    input  wire logic        pc_we_i,
    input  wire logic [31:0] pc_wdata_i,
    output logic      [31:0] pc_o,
    // Exception entry and return
    input  wire logic        exception_interrupt_trap_i,
    input  wire logic        return_from_exception_i,
    // Interrupt gating
    input  wire logic        irq_req_i,
    output logic             irq_accept_o,
    // Accumulator
    input  wire logic        acc_we_i,
    input  wire logic [55:0] acc_wdata_i,
    output logic      [55:0] acc_o,
    // Status views
    output logic      [31:0] processor_status_word_o,
    output logic      [31:0] condition_mirror_o,
    output logic             stack_select_o,
    output logic             interrupt_accept_enable_o
);

    typedef struct packed {
        logic [31:0] status;
        logic [31:0] isp;
        logic [31:0] usp;
        logic [31:0] saved_pc;
        logic [31:0] pc;
        logic [55:0] acc;
        logic [31:0] ctl_q;
        logic [31:0] sp_a;
        logic [31:0] sp_b;
        logic        sel_sp_a;
        logic        sel_sp_b;
    } core_state_s;

    core_state_s st_reg;
    core_state_s st_next;

    logic        mem_we;
    logic [3:0]  mem_waddr;
    logic [31:0] mem_wdata;
    logic [31:0] mem_rdata_a;
    logic [31:0] mem_rdata_b;
    logic        stack_sel;
    logic [31:0] mirror_val;
    logic [31:0] sp_live;

    assign stack_sel  = st_reg.status[cpu_regs_pkg::STACK_SEL_BIT];
    assign sp_live    = stack_sel ? st_reg.usp : st_reg.isp;
    assign mirror_val = {31'h0000_0000,
                         st_reg.status[cpu_regs_pkg::COND_BIT]};

    // RAM write: a call owns the link register, stack alias stays out
    always_comb begin
        mem_we    = call_i ||
                    (gpr_we_i && !cpu_regs_pkg::is_sp(gpr_waddr_i));
        mem_waddr = call_i ? cpu_regs_pkg::LINK_IDX : gpr_waddr_i;
        mem_wdata = call_i ? ret_addr_i : gpr_wdata_i;
    end

    gpr_mem u_gpr_mem (
        .ref_clk_i (ref_clk_i),
        .rstn_i    (rstn_i),
        .we_i      (mem_we),
        .waddr_i   (mem_waddr),
        .wdata_i   (mem_wdata),
        .raddr_a_i (gpr_raddr_a_i),
        .raddr_b_i (gpr_raddr_b_i),
        .rdata_a_o (mem_rdata_a),
        .rdata_b_o (mem_rdata_b)
    );

    // Next state of control registers, PC, accumulator and read buffers
    always_comb begin
        st_next = st_reg;
        // Stack alias write through register fifteen
        if (gpr_we_i && cpu_regs_pkg::is_sp(gpr_waddr_i)) begin
            if (stack_sel) begin
                st_next.usp = gpr_wdata_i;
            end else begin
                st_next.isp = gpr_wdata_i;
            end
        end
        // Control moves; the condition mirror slot takes nothing
        if (move_to_control_i) begin
            case (ctl_waddr_i)
                cpu_regs_pkg::CR_STATUS: begin
                    st_next.status = ctl_wdata_i &
                                     cpu_regs_pkg::STATUS_WMASK;
                end
                cpu_regs_pkg::CR_ISP: begin
                    st_next.isp = ctl_wdata_i;
                end
                cpu_regs_pkg::CR_USP: begin
                    st_next.usp = ctl_wdata_i;
                end
                cpu_regs_pkg::CR_SAVED_PC: begin
                    st_next.saved_pc = ctl_wdata_i;
                end
                default: begin
                end
            endcase
        end
        // Execution updates the condition flag
        if (cond_we_i) begin
            st_next.status[cpu_regs_pkg::COND_BIT] = cond_i;
        end
        // Program counter
        if (pc_we_i) begin
            st_next.pc = pc_wdata_i;
        end
        // Return restores PC word-aligned and live bits from backup
        if (return_from_exception_i) begin
            st_next.pc = st_reg.saved_pc & cpu_regs_pkg::PC_ALIGN;
            st_next.status[cpu_regs_pkg::STACK_SEL_BIT] =
                st_reg.status[cpu_regs_pkg::SAVED_STACK_BIT];
            st_next.status[cpu_regs_pkg::IRQ_EN_BIT] =
                st_reg.status[cpu_regs_pkg::SAVED_IRQ_BIT];
            st_next.status[cpu_regs_pkg::COND_BIT] =
                st_reg.status[cpu_regs_pkg::SAVED_COND_BIT];
        end
        // Exception entry saves PC and live bits, winning over other writes
        if (exception_interrupt_trap_i) begin
            st_next.saved_pc = st_reg.pc;
            st_next.status[cpu_regs_pkg::SAVED_STACK_BIT] =
                st_reg.status[cpu_regs_pkg::STACK_SEL_BIT];
            st_next.status[cpu_regs_pkg::SAVED_IRQ_BIT] =
                st_reg.status[cpu_regs_pkg::IRQ_EN_BIT];
            st_next.status[cpu_regs_pkg::SAVED_COND_BIT] =
                st_reg.status[cpu_regs_pkg::COND_BIT];
        end
        // Accumulator
        if (acc_we_i) begin
            st_next.acc = acc_wdata_i;
        end
        // Control read, unmapped numbers return zero
        case (ctl_raddr_i)
            cpu_regs_pkg::CR_STATUS: st_next.ctl_q = st_reg.status;
            cpu_regs_pkg::CR_MIRROR: st_next.ctl_q = mirror_val;
            cpu_regs_pkg::CR_ISP: st_next.ctl_q = st_reg.isp;
            cpu_regs_pkg::CR_USP: st_next.ctl_q = st_reg.usp;
            cpu_regs_pkg::CR_SAVED_PC: st_next.ctl_q = st_reg.saved_pc;
            default:              st_next.ctl_q = cpu_regs_pkg::WORD_ZERO;
        endcase
        // Stack alias snapshots for the general read ports
        st_next.sp_a     = sp_live;
        st_next.sp_b     = sp_live;
        st_next.sel_sp_a = cpu_regs_pkg::is_sp(gpr_raddr_a_i);
        st_next.sel_sp_b = cpu_regs_pkg::is_sp(gpr_raddr_b_i);
    end

    // State register; backup bits get zero though software may not rely on it
    always_ff @(posedge ref_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            st_reg        <= '0;
            st_reg.status <= cpu_regs_pkg::STATUS_RESET;
            st_reg.acc <= cpu_regs_pkg::ACC_RESET;
        end else begin
            st_reg <= st_next;
        end
    end

    // Outputs
    assign gpr_rdata_a_o = st_reg.sel_sp_a ? st_reg.sp_a : mem_rdata_a;
    assign gpr_rdata_b_o = st_reg.sel_sp_b ? st_reg.sp_b : mem_rdata_b;
    assign ctl_rdata_o   = st_reg.ctl_q;
    assign pc_o          = st_reg.pc;
    assign acc_o         = st_reg.acc;
    assign processor_status_word_o   = st_reg.status;
    assign condition_mirror_o        = mirror_val;
    assign stack_select_o            = stack_sel;
    assign interrupt_accept_enable_o =
        st_reg.status[cpu_regs_pkg::IRQ_EN_BIT];
    assign irq_accept_o = irq_req_i && interrupt_accept_enable_o;

    // Checks on the behaviour above
    default clocking cb @(posedge ref_clk_i); endclocking
    default disable iff (!rstn_i);

    property p_link;
        call_i |-> mem_we && mem_waddr == 4'he && mem_wdata == ret_addr_i;
    endproperty
    a_link: assert property (p_link)
        else $error("call did not write link register");

    property p_sp_bank;
        gpr_we_i && gpr_waddr_i == 4'hf && !move_to_control_i
        |=> ($past(stack_sel) ? st_reg.usp : st_reg.isp) ==
            $past(gpr_wdata_i);
    endproperty
    a_sp_bank: assert property (p_sp_bank)
        else $error("stack alias write went to wrong pointer");

    property p_backup;
        exception_interrupt_trap_i |=>
            st_reg.status[16] == $past(st_reg.status[24]) &&
            st_reg.status[17] == $past(st_reg.status[25]) &&
            st_reg.status[23] == $past(st_reg.status[31]);
    endproperty
    a_backup: assert property (p_backup)
        else $error("backup status bits not saved on exception");

    property p_mirror;
        condition_mirror_o == {31'h0000_0000, processor_status_word_o[31]};
    endproperty
    a_mirror: assert property (p_mirror)
        else $error("condition mirror differs from condition flag");

    property p_mirror_ro;
        move_to_control_i && ctl_waddr_i == 3'h1 && !cond_we_i &&
        !exception_interrupt_trap_i && !return_from_exception_i &&
        !gpr_we_i |=> $stable(st_reg.status) && $stable(st_reg.isp) &&
        $stable(st_reg.usp) && $stable(st_reg.saved_pc);
    endproperty
    a_mirror_ro: assert property (p_mirror_ro)
        else $error("write to condition mirror changed state");

    property p_bpc_save;
        exception_interrupt_trap_i |=> st_reg.saved_pc == $past(st_reg.pc);
    endproperty
    a_bpc_save: assert property (p_bpc_save)
        else $error("backup PC not saved on exception");

    property p_rte;
        return_from_exception_i |=> pc_o[1:0] == 2'h0 &&
            pc_o[31:2] == $past(st_reg.saved_pc[31:2]);
    endproperty
    a_rte: assert property (p_rte)
        else $error("return did not restore aligned PC");

    property p_reserved;
        (processor_status_word_o & ~32'h8383_0000) == 32'h0000_0000;
    endproperty
    a_reserved: assert property (p_reserved)
        else $error("unassigned status bit is set");

    property p_irq_gate;
        irq_accept_o |-> processor_status_word_o[25] && irq_req_i;
    endproperty
    a_irq_gate: assert property (p_irq_gate)
        else $error("interrupt accepted while disabled");

    property p_cond;
        cond_we_i && !return_from_exception_i
        |=> processor_status_word_o[31] == $past(cond_i);
    endproperty
    a_cond: assert property (p_cond)
        else $error("condition flag not updated");

    property p_acc;
        acc_we_i |=> acc_o == $past(acc_wdata_i);
    endproperty
    a_acc: assert property (p_acc)
        else $error("accumulator write lost");

endmodule

// File: verif/core_exec_model.sv
// Far-side stand-in: core logic raising interrupt requests as a level
`timescale 1ns/1ps
module core_exec_model (
    // Clock and reset
    input  wire logic ref_clk_i,
    input  wire logic rstn_i,
    // Interrupt request towards the register file
    output logic      irq_req_o
);
    logic [3:0] cnt_reg;

    // Request level changes just after a rising edge, in an uneven pattern
    always_ff @(posedge ref_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            cnt_reg   <= 4'h0;
            irq_req_o <= 1'b0;
        end else begin
            cnt_reg   <= cnt_reg + 4'h1;
            irq_req_o <= cnt_reg[1] ^ cnt_reg[3];
        end
    end
endmodule

// File: verif/cpu_register_file_and_status_word_bench.sv
// Self-checking bench: random core traffic against a behavioural model
`timescale 1ns/1ps
module cpu_register_file_and_status_word_bench;
    // Stimulus, all driven just after the rising edge
    logic        ref_clk_i = 1'b0, rstn_i = 1'b0;
    logic [3:0]  gpr_raddr_a_i = 4'h0, gpr_raddr_b_i = 4'h0;
    logic [3:0]  gpr_waddr_i = 4'h0;
    logic [2:0]  ctl_waddr_i = 3'h0, ctl_raddr_i = 3'h0;
    logic [31:0] gpr_wdata_i = 32'h0, ret_addr_i = 32'h0;
    logic [31:0] ctl_wdata_i = 32'h0, pc_wdata_i = 32'h0;
    logic [55:0] acc_wdata_i = 56'h0;
    logic        gpr_we_i = 1'b0, call_i = 1'b0, move_to_control_i = 1'b0;
    logic        cond_we_i = 1'b0, cond_i = 1'b0, pc_we_i = 1'b0;
    logic        acc_we_i = 1'b0, exc_i = 1'b0, ret_i = 1'b0;
    logic        irq_req_i;
    // Design outputs
    logic [31:0] gpr_rdata_a_o, gpr_rdata_b_o, ctl_rdata_o, pc_o;
    logic [31:0] processor_status_word_o, condition_mirror_o;
    logic [55:0] acc_o;
    logic        irq_accept_o, stack_select_o, interrupt_accept_enable_o;
    // Behavioural model and expectation pipeline
    logic [31:0] g [15];
    logic [31:0] isp, usp, st, spc, pc, ea, eb, ec, pa, pb, pcr, s_st, s_pc;
    logic [55:0] acc, s_acc;
    logic [31:0] seed = 32'h0001_6622;
    int          error_cnt = 0;
    int          num_checks = 0;

    cpu_register_file dut_u (
        .ref_clk_i(ref_clk_i), .rstn_i(rstn_i),
        .gpr_raddr_a_i(gpr_raddr_a_i), .gpr_raddr_b_i(gpr_raddr_b_i),
        .gpr_rdata_a_o(gpr_rdata_a_o), .gpr_rdata_b_o(gpr_rdata_b_o),
        .gpr_we_i(gpr_we_i), .gpr_waddr_i(gpr_waddr_i),
        .gpr_wdata_i(gpr_wdata_i), .call_i(call_i), .ret_addr_i(ret_addr_i),
        .move_to_control_i(move_to_control_i), .ctl_waddr_i(ctl_waddr_i),
        .ctl_wdata_i(ctl_wdata_i), .ctl_raddr_i(ctl_raddr_i),
        .ctl_rdata_o(ctl_rdata_o), .cond_we_i(cond_we_i), .cond_i(cond_i),
        .pc_we_i(pc_we_i), .pc_wdata_i(pc_wdata_i), .pc_o(pc_o),
        .exception_interrupt_trap_i(exc_i), .return_from_exception_i(ret_i),
        .irq_req_i(irq_req_i), .irq_accept_o(irq_accept_o),
        .acc_we_i(acc_we_i), .acc_wdata_i(acc_wdata_i), .acc_o(acc_o),
        .processor_status_word_o(processor_status_word_o),
        .condition_mirror_o(condition_mirror_o),
        .stack_select_o(stack_select_o),
        .interrupt_accept_enable_o(interrupt_accept_enable_o)
    );

    core_exec_model model_u (
        .ref_clk_i(ref_clk_i), .rstn_i(rstn_i), .irq_req_o(irq_req_i)
    );

    // Free-running 200 MHz clock
    initial begin
        forever #2.5 ref_clk_i = ~ref_clk_i;
    end

    // Fixed-seed xorshift source
    function automatic logic [31:0] xs();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction

    // Model view of a general register read
    function automatic logic [31:0] grd(input logic [3:0] a);
        if (a == 4'hf) return st[24] ? usp : isp;
        return g[a];
    endfunction

    // Model view of a control register read
    function automatic logic [31:0] crd(input logic [2:0] a);
        case (a)
            3'h0: return st;
            3'h1: return {31'h0, st[31]};
            3'h2: return isp;
            3'h3: return usp;
            3'h6: return spc;
            default: return 32'h0;
        endcase
    endfunction

    // Compare one value, count it, report a mismatch
    task automatic chk(input logic [55:0] seen, input logic [55:0] exp);
        num_checks++;
        if (seen !== exp) begin
            error_cnt++;
            $display("FAIL %0t seen %h expected %h", $time, seen, exp);
        end
    endtask

    // Verdict and end of run
    task automatic complete_run();
        if (error_cnt == 0 && num_checks > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask

    // Hold reset three cycles with all requests dropped; model back to zero
    task automatic do_reset();
        @(posedge ref_clk_i);
        rstn_i <= 1'b0;
        {gpr_we_i, call_i, move_to_control_i, cond_we_i} <= 4'h0;
        {pc_we_i, acc_we_i, exc_i, ret_i} <= 4'h0;
        {st, isp, usp, spc, pc, ea, eb, ec} = '0;
        acc = 56'h0;
        foreach (g[i]) g[i] = 32'h0;
        repeat (3) @(posedge ref_clk_i);
        #1 chk(56'(processor_status_word_o & 32'h8300_0000), 56'h0);
        rstn_i <= 1'b1;
    endtask

    // One cycle of traffic: drive, step the model, check the previous cycle
    task automatic step(input logic [3:0] fop, input bit chk_on);
        logic [31:0] r, x, y, z;
        logic [3:0]  op;
        @(posedge ref_clk_i);
        pa = ea; pb = eb; pcr = ec; s_st = st; s_pc = pc; s_acc = acc;
        r = xs(); x = xs(); y = xs(); z = xs();
        op = r[3:0] % 4'h9;
        if (fop != 4'hf) begin
            op = fop;
            r[26:24] = 3'h0;
        end
        // Reads see the state before this cycle's write
        ea = grd(r[11:8]);
        eb = grd(r[15:12]);
        ec = crd(r[18:16]);
        gpr_raddr_a_i <= r[11:8];
        gpr_raddr_b_i <= r[15:12];
        ctl_raddr_i <= r[18:16];
        gpr_waddr_i <= r[23:20];
        ctl_waddr_i <= r[26:24];
        cond_i <= r[27];
        gpr_wdata_i <= x;
        ctl_wdata_i <= x;
        ret_addr_i <= y;
        pc_wdata_i <= y;
        acc_wdata_i <= {z[23:0], x};
        gpr_we_i <= (op == 4'h0);
        call_i <= (op == 4'h1);
        move_to_control_i <= (op == 4'h2);
        cond_we_i <= (op == 4'h3);
        pc_we_i <= (op == 4'h4);
        acc_we_i <= (op == 4'h5);
        exc_i <= (op == 4'h6);
        ret_i <= (op == 4'h7);
        case (op)
            4'h0: begin
                if (r[23:20] != 4'hf) g[r[23:20]] = x;
                else if (st[24]) usp = x;
                else isp = x;
            end
            4'h1: g[14] = y;
            4'h2: begin
                case (r[26:24])
                    3'h0: st = x & 32'h8383_0000;
                    3'h2: isp = x;
                    3'h3: usp = x;
                    3'h6: spc = x;
                    default: ;
                endcase
            end
            4'h3: st[31] = r[27];
            4'h4: pc = y;
            4'h5: acc = {z[23:0], x};
            4'h6: begin
                spc = pc;
                {st[23], st[17], st[16]} = {st[31], st[25], st[24]};
            end
            4'h7: begin
                pc = spc & 32'hffff_fffc;
                {st[31], st[25], st[24]} = {st[23], st[17], st[16]};
            end
            default: ;
        endcase
        @(negedge ref_clk_i);
        if (chk_on) begin
            chk(56'(gpr_rdata_a_o), 56'(pa));
            chk(56'(gpr_rdata_b_o), 56'(pb));
            chk(56'(ctl_rdata_o), 56'(pcr));
            chk(56'(processor_status_word_o), 56'(s_st));
            chk(56'(condition_mirror_o), 56'(s_st[31]));
            chk(56'(stack_select_o), 56'(s_st[24]));
            chk(56'(interrupt_accept_enable_o), 56'(s_st[25]));
            chk(56'(irq_accept_o), 56'(irq_req_i & s_st[25]));
            chk(56'(pc_o), 56'(s_pc));
            chk(acc_o, s_acc);
        end
    endtask

    // Two runs, the second after a reset in mid-traffic
    initial begin
        for (int n = 0; n < 2; n++) begin
            do_reset();
            step(4'h2, 1'b0);
            step(4'h8, 1'b0);
            repeat (2000) step(4'hf, 1'b1);
        end
        complete_run();
    end

    // Watchdog against a hang
    initial begin
        #50000;
        error_cnt++;
        complete_run();
    end
endmodule
